// ===== hdl/lcd_command_decoder_defines.svh
// Purpose: constants of the character lcd command decoder
// Assumes: 40 MHz sys_clk
// Notes: offsets, field positions, reset values and timing counts
`ifndef LCD_COMMAND_DECODER_DEFINES_SVH
`define LCD_COMMAND_DECODER_DEFINES_SVH
// opcodes in data[7:4] of a command byte
`define LCD_OP_TEST 4'h0
`define LCD_OP_HOME 4'h1
`define LCD_OP_LINE 4'h2
`define LCD_OP_DISP 4'h3
`define LCD_OP_PSAVE 4'h4
`define LCD_OP_POWER 4'h5
`define LCD_OP_SYSTEM 4'h6
`define LCD_NOP_BYTE 8'h00
`define LCD_ADDR_SET_BIT 7
// address counter preset of cursor home
`define LCD_HOME_ADDR 7'h30
// normal-bank data spaces below character display ram
`define LCD_ICON_ON_BASE 7'h00
`define LCD_ICON_BLINK_BASE 7'h10
`define LCD_CONTRAST_ADDR 7'h20
`define LCD_ICON_COUNT 7'h0A
// reset values
`define LCD_SCROLL_RST 2'h0
`define LCD_LINE_RST 4'h0
`define LCD_DISP_RST 4'h0
`define LCD_PSAVE_RST 2'h0
`define LCD_POWER_RST 4'h0
`define LCD_BIAS_RST 4'h8
`define LCD_SYSTEM_RST 4'h0
`define LCD_CONTRAST_RST 5'h00
`define LCD_ICON_RST 10'h000
`define LCD_ADDR_RST 7'h00
// timing
`define LCD_CLK_PERIOD_NS 25
`define LCD_RESUME_NS 1000
`define LCD_RESUME_CYC \
  ((`LCD_RESUME_NS + `LCD_CLK_PERIOD_NS - 1) / `LCD_CLK_PERIOD_NS)
`endif

// ===== hdl/lcd_command_decoder_pkg.sv
// Purpose: types of the character lcd command decoder
// Assumes: nothing
// Notes: field order matches the data bits d3..d0 of each command, d1..d0 for power save
package lcd_command_decoder_pkg;
  typedef struct packed {
    logic cursor_on;
    logic cursor_blink;
    logic ext_bank_select;
    logic display_on;
  } display_cursor_s;
  typedef struct packed {
    logic osc_run;
    logic power_save;
  } power_save_s;
  typedef struct packed {
    logic high_drive;
    logic regulator_on;
    logic follower_on;
    logic booster_on;
  } power_circuit_s;
  typedef struct packed {
    logic internal_divider_sel;
    logic bias_select;
    logic [1:0] divider_ratio;
  } bias_divider_s;
  typedef struct packed {
    logic [1:0] font_rom_sel;
    logic com_scan_dir;
    logic user_glyph_ram_en;
  } system_config_s;
  typedef struct packed {
    logic en;
    logic ext_space;
    logic [6:0] addr;
    logic [7:0] data;
  } ram_write_s;
endpackage : lcd_command_decoder_pkg

// ===== hdl/lcd_command_decoder.sv
// Purpose: command decoder and reset setup of a character lcd driver
// Assumes: host bus inputs synchronous to sys_clk
// Notes: a write is decoded when wr_n rises, using the bus seen while low
`timescale 1ns/100ps
`include "lcd_command_decoder_defines.svh"
module lcd_command_decoder #(
  parameter int RESUME_CYC = `LCD_RESUME_CYC
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wr_n,
  input wire logic cmd_data_select,
  input wire logic [7:0] data_in,
  output logic ready,
  output logic test_mode,
  output logic [1:0] line_scroll_amount,
  output logic [3:0] reverse_blink_flags,
  output logic [3:0] line_double_height_flags,
  output lcd_command_decoder_pkg::display_cursor_s display_cursor_control,
  output lcd_command_decoder_pkg::power_save_s power_save_control,
  output lcd_command_decoder_pkg::power_circuit_s power_circuit_control,
  output lcd_command_decoder_pkg::bias_divider_s bias_divider_control,
  output lcd_command_decoder_pkg::system_config_s system_configuration,
  output logic glyph_inversion_config,
  output logic [4:0] contrast,
  output logic [9:0] icon_segment_on,
  output logic [9:0] icon_segment_blink,
  output logic [6:0] address_counter,
  output logic addr_space_ext,
  output logic cursor_home_move,
  output lcd_command_decoder_pkg::ram_write_s ram_write
);
  logic wr_n_prev_reg;
  logic [7:0] cap_data_reg;
  logic cap_a0_reg;
  logic [6:0] resume_cnt_reg;
  logic last_access_ext_reg;
  logic write_done;
  logic fire;
  logic cmd_fire;
  logic data_fire;
  logic ext;
  logic [3:0] op;
  logic [6:0] icon_on_idx;
  logic [6:0] icon_blink_idx;

  // strobe completion detect; bus is latched while wr_n is low
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_n_prev_reg <= 1'b1;
      cap_data_reg <= 8'h00;
      cap_a0_reg <= 1'b0;
    end
    else
    begin
      wr_n_prev_reg <= wr_n;
      if (!wr_n)
      begin
        cap_data_reg <= data_in;
        cap_a0_reg <= cmd_data_select;
      end
    end
  end

  // one decode per low-to-high edge of wr_n once ready is high
  assign write_done = !wr_n_prev_reg && wr_n;
  assign fire = write_done && ready;
  assign cmd_fire = fire && !cap_a0_reg;
  assign data_fire = fire && cap_a0_reg;
  assign ext = display_cursor_control.ext_bank_select;
  assign op = cap_data_reg[7:4];
  assign icon_on_idx = address_counter - `LCD_ICON_ON_BASE;
  assign icon_blink_idx = address_counter - `LCD_ICON_BLINK_BASE;

  // writes are dropped until the resume time after reset has run out
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resume_cnt_reg <= 7'h00;
      ready <= 1'b0;
    end
    else if (!ready)
    begin
      resume_cnt_reg <= resume_cnt_reg + 7'h01;
      if (resume_cnt_reg == 7'(RESUME_CYC - 1))
        ready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      test_mode <= 1'b0;
    else if (cmd_fire && op == `LCD_OP_TEST)
      test_mode <= (cap_data_reg[3:0] != 4'h0);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      line_scroll_amount <= `LCD_SCROLL_RST;
    else if (cmd_fire && op == `LCD_OP_HOME)
    begin
      if (ext)
        line_scroll_amount <= cap_data_reg[1:0];
      else
        line_scroll_amount <= `LCD_SCROLL_RST;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reverse_blink_flags <= `LCD_LINE_RST;
      line_double_height_flags <= `LCD_LINE_RST;
    end
    else if (cmd_fire && op == `LCD_OP_LINE)
    begin
      if (ext)
        line_double_height_flags <= cap_data_reg[3:0];
      else
        reverse_blink_flags <= cap_data_reg[3:0];
    end
  end

  // accepted in both banks; new bank governs the next byte
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      display_cursor_control <= `LCD_DISP_RST;
    else if (cmd_fire && op == `LCD_OP_DISP)
      display_cursor_control <= cap_data_reg[3:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      power_save_control <= `LCD_PSAVE_RST;
    else if (cmd_fire && op == `LCD_OP_PSAVE)
      power_save_control <= cap_data_reg[1:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      power_circuit_control <= `LCD_POWER_RST;
      bias_divider_control <= `LCD_BIAS_RST;
    end
    else if (cmd_fire && op == `LCD_OP_POWER)
    begin
      if (ext)
        bias_divider_control <= cap_data_reg[3:0];
      else
        power_circuit_control <= cap_data_reg[3:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      system_configuration <= `LCD_SYSTEM_RST;
      glyph_inversion_config <= 1'b0;
    end
    else if (cmd_fire && op == `LCD_OP_SYSTEM)
    begin
      if (ext)
        glyph_inversion_config <= cap_data_reg[1];
      else
        system_configuration <= cap_data_reg[3:0];
    end
  end

  // address counter and the space it points into
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      address_counter <= `LCD_ADDR_RST;
      addr_space_ext <= 1'b0;
    end
    else if (cmd_fire && cap_data_reg[`LCD_ADDR_SET_BIT])
    begin
      address_counter <= cap_data_reg[6:0];
      addr_space_ext <= ext;
    end
    else if (cmd_fire && op == `LCD_OP_HOME && !ext)
    begin
      address_counter <= `LCD_HOME_ADDR;
      addr_space_ext <= 1'b0;
    end
    else if (data_fire)
      address_counter <= address_counter + 7'h01;
  end

  // cursor jumps home only if the previous ram access was normal-bank
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_access_ext_reg <= 1'b0;
      cursor_home_move <= 1'b0;
    end
    else
    begin
      if (data_fire)
        last_access_ext_reg <= addr_space_ext;
      cursor_home_move <= cmd_fire && op == `LCD_OP_HOME && !ext &&
        display_cursor_control.cursor_on && !last_access_ext_reg;
    end
  end

  // data bytes leave as a one-cycle write; icon and contrast kept here
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ram_write <= '0;
    else
    begin
      ram_write.en <= data_fire;
      if (data_fire)
      begin
        ram_write.ext_space <= addr_space_ext;
        ram_write.addr <= address_counter;
        ram_write.data <= cap_data_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      contrast <= `LCD_CONTRAST_RST;
      icon_segment_on <= `LCD_ICON_RST;
      icon_segment_blink <= `LCD_ICON_RST;
    end
    else if (data_fire && !addr_space_ext)
    begin
      if (address_counter == `LCD_CONTRAST_ADDR)
        contrast <= cap_data_reg[4:0];
      else if (icon_on_idx < `LCD_ICON_COUNT)
        icon_segment_on[icon_on_idx[3:0]] <= cap_data_reg[0];
      else if (icon_blink_idx < `LCD_ICON_COUNT)
        icon_segment_blink[icon_blink_idx[3:0]] <= cap_data_reg[0];
    end
  end

  sequence s_cmd(logic [3:0] code, logic bank);
    !wr_n_prev_reg && wr_n && ready && !cap_a0_reg &&
      cap_data_reg[7:4] == code && ext == bank;
  endsequence

  sequence s_data;
    !wr_n_prev_reg && wr_n && ready && cap_a0_reg;
  endsequence

  sequence s_addr_set;
    !wr_n_prev_reg && wr_n && ready && !cap_a0_reg &&
      cap_data_reg[`LCD_ADDR_SET_BIT];
  endsequence

  property p_reset_init;
    @(posedge sys_clk) disable iff (!reset_n)
    !$past(reset_n) |-> line_double_height_flags == 4'h0 &&
      display_cursor_control == 4'h0 && power_save_control == 2'h0 &&
      bias_divider_control == 4'h8 && power_circuit_control == 4'h0 &&
      system_configuration == 4'h0 && contrast == 5'h00 &&
      icon_segment_on == 10'h000 && !ready;
  endproperty
  a_reset_init: assert property (p_reset_init)
    else $error("setup state wrong after reset");

  property p_resume;
    @(posedge sys_clk) disable iff (!reset_n)
    !ready |-> !ram_write.en ##1 !ram_write.en;
  endproperty
  a_resume: assert property (p_resume)
    else $error("write accepted before resume time");

  property p_home;
    @(posedge sys_clk) disable iff (!reset_n)
    s_cmd(`LCD_OP_HOME, 1'b0) ##0 !cap_data_reg[7] |=>
      address_counter == 7'h30 && line_scroll_amount == 2'h0;
  endproperty
  a_home: assert property (p_home)
    else $error("cursor home did not preset address and scroll");

  property p_scroll;
    @(posedge sys_clk) disable iff (!reset_n)
    s_cmd(`LCD_OP_HOME, 1'b1) |=>
      line_scroll_amount == $past(cap_data_reg[1:0]);
  endproperty
  a_scroll: assert property (p_scroll)
    else $error("scroll amount not loaded");

  property p_bank;
    @(posedge sys_clk) disable iff (!reset_n)
    s_cmd(`LCD_OP_DISP, 1'b0) ##0 cap_data_reg[1] |=>
      (ext && display_cursor_control == $past(cap_data_reg[3:0])) ##1 ext;
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank change lost");

  property p_power_ext;
    @(posedge sys_clk) disable iff (!reset_n)
    s_cmd(`LCD_OP_POWER, 1'b1) |=> $stable(power_circuit_control) &&
      bias_divider_control == $past(cap_data_reg[3:0]);
  endproperty
  a_power_ext: assert property (p_power_ext)
    else $error("extended power command hit wrong register");

  property p_data_inc;
    @(posedge sys_clk) disable iff (!reset_n)
    s_data |=> ram_write.en && ram_write.addr == $past(address_counter)
      && address_counter == $past(address_counter) + 7'h01;
  endproperty
  a_data_inc: assert property (p_data_inc)
    else $error("data write did not advance address");

  property p_once;
    @(posedge sys_clk) disable iff (!reset_n)
    ram_write.en |=> !ram_write.en;
  endproperty
  a_once: assert property (p_once)
    else $error("one strobe decoded twice");

  property p_nop;
    @(posedge sys_clk) disable iff (!reset_n)
    s_cmd(`LCD_OP_TEST, ext) ##0 cap_data_reg == `LCD_NOP_BYTE |=>
      !test_mode && $stable(address_counter) && $stable(contrast);
  endproperty
  a_nop: assert property (p_nop)
    else $error("no-op changed state or kept test mode");

  property p_addr_set;
    @(posedge sys_clk) disable iff (!reset_n)
    s_addr_set |=> address_counter == $past(cap_data_reg[6:0]) &&
      addr_space_ext == $past(ext);
  endproperty
  a_addr_set: assert property (p_addr_set)
    else $error("address set did not load the counter");

  property p_line;
    @(posedge sys_clk) disable iff (!reset_n)
    s_cmd(`LCD_OP_LINE, 1'b1) |=> $stable(reverse_blink_flags) &&
      line_double_height_flags == $past(cap_data_reg[3:0]);
  endproperty
  a_line: assert property (p_line)
    else $error("extended line command hit wrong flags");

  property p_psave;
    @(posedge sys_clk) disable iff (!reset_n)
    s_cmd(`LCD_OP_PSAVE, ext) |=>
      power_save_control == $past(cap_data_reg[1:0]);
  endproperty
  a_psave: assert property (p_psave)
    else $error("power save command not loaded");
endmodule : lcd_command_decoder

// ===== tb/lcd_host_model.sv
// Purpose: host processor on the parallel write-only bus
// Assumes: device samples the bus on sys_clk
// Notes: data lines show the inverse byte between strobes
`timescale 1ns/100ps
module lcd_host_model
(
  input wire logic sys_clk,
  input wire logic ready,
  output logic wr_n,
  output logic cmd_data_select,
  output logic [7:0] data_in
);
  initial
  begin
    wr_n = 1'b1;
    cmd_data_select = 1'b0;
    data_in = 8'h00;
  end
  // rdy=0 lets a scenario write too early on purpose
  task automatic write(input logic sel, input logic [7:0] b,
    input int lo, input bit rdy);
    int n;
    n = 0;
    while (rdy && ready !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    wr_n <= 1'b0;
    cmd_data_select <= sel;
    data_in <= b;
    repeat (lo) @(posedge sys_clk);
    wr_n <= 1'b1;
    @(posedge sys_clk);
    // released lines must not keep the last byte
    data_in <= ~b;
  endtask : write
endmodule : lcd_host_model

// ===== tb/lcd_command_decoder_tb.sv
// Purpose: self-checking bench of the lcd command decoder
// Assumes: host model drives the bus, a reference model predicts
// Notes: all outputs but ready compared after each completed strobe
`timescale 1ns/100ps
module lcd_command_decoder_tb;
  localparam int RC = 40;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr_n, sel, ready, test_mode, gi_o, ext_o, home_o;
  logic [7:0] din;
  logic [1:0] scr_o;
  logic [3:0] rb_o, dh_o;
  logic [4:0] con_o;
  logic [9:0] ion_o, ibl_o;
  logic [6:0] ac_o;
  lcd_command_decoder_pkg::display_cursor_s dc_o;
  lcd_command_decoder_pkg::power_save_s ps_o;
  lcd_command_decoder_pkg::power_circuit_s pc_o;
  lcd_command_decoder_pkg::bias_divider_s bd_o;
  lcd_command_decoder_pkg::system_config_s sc_o;
  lcd_command_decoder_pkg::ram_write_s rw_o;
  logic [1:0] scr, ps;
  logic [3:0] rb, dh, dc, pc, bd, sc;
  logic [4:0] con;
  logic [9:0] ion, ibl;
  logic [6:0] ac;
  logic [15:0] rw;
  logic gi, ext, lx, wen, home, tm;
  logic [7:0] b;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 25;
  always #12.5 sys_clk = ~sys_clk;
  lcd_host_model lcd_host_model_inst (.sys_clk(sys_clk), .ready(ready),
    .wr_n(wr_n), .cmd_data_select(sel), .data_in(din));
  lcd_command_decoder #(.RESUME_CYC(RC)) lcd_command_decoder_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .wr_n(wr_n),
    .cmd_data_select(sel), .data_in(din), .ready(ready),
    .test_mode(test_mode), .line_scroll_amount(scr_o),
    .reverse_blink_flags(rb_o), .line_double_height_flags(dh_o),
    .display_cursor_control(dc_o), .power_save_control(ps_o),
    .power_circuit_control(pc_o), .bias_divider_control(bd_o),
    .system_configuration(sc_o), .glyph_inversion_config(gi_o),
    .contrast(con_o), .icon_segment_on(ion_o),
    .icon_segment_blink(ibl_o), .address_counter(ac_o),
    .addr_space_ext(ext_o), .cursor_home_move(home_o), .ram_write(rw_o));
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic mreset;
    {scr, ps, rb, dh, dc, pc, sc, con, ion, ibl, ac, rw} = '0;
    {gi, ext, lx, wen, home, tm} = '0;
    bd = 4'h8;
  endtask : mreset
  task automatic apply(logic s, logic [7:0] v);
    wen = s;
    home = 1'b0;
    if (s)
    begin
      rw = {ext, ac, v};
      lx = ext;
      if (!ext && ac < 7'h0A)
        ion[ac] = v[0];
      if (!ext && ac >= 7'h10 && ac < 7'h1A)
        ibl[ac - 7'h10] = v[0];
      if (!ext && ac == 7'h20)
        con = v[4:0];
      ac = ac + 7'h01;
    end
    else if (v[7])
    begin
      ac = v[6:0];
      ext = dc[1];
    end
    else
      case ({dc[1], v[6:4]})
        4'h1:
        begin
          ac = 7'h30;
          scr = 2'h0;
          ext = 1'b0;
          home = dc[3] & ~lx;
        end
        4'h9: scr = v[1:0];
        4'h2: rb = v[3:0];
        4'hA: dh = v[3:0];
        4'h3, 4'hB: dc = v[3:0];
        4'h4, 4'hC: ps = v[1:0];
        4'h5: pc = v[3:0];
        4'hD: bd = v[3:0];
        4'h6: sc = v[3:0];
        4'hE: gi = v[1];
        4'h0, 4'h8: tm = (v[3:0] != 4'h0);
        default: ;
      endcase
  endtask : apply
  task automatic check_all;
    chk("scroll", scr_o, scr);
    chk("rblink", rb_o, rb);
    chk("dheight", dh_o, dh);
    chk("disp", dc_o, dc);
    chk("psave", ps_o, ps);
    chk("power", pc_o, pc);
    chk("bias", bd_o, bd);
    chk("sys", sc_o, sc);
    chk("inv", gi_o, gi);
    chk("contrast", con_o, con);
    chk("icon_on", ion_o, ion);
    chk("icon_blk", ibl_o, ibl);
    chk("addr", ac_o, ac);
    chk("space", ext_o, ext);
    chk("home", home_o, home);
    chk("test", test_mode, tm);
    chk("wr_en", rw_o.en, wen);
    chk("wr", rw_o[15:0], rw);
  endtask : check_all
  task automatic wr(logic s, logic [7:0] v, int lo);
    lcd_host_model_inst.write(s, v, lo, 1'b1);
    apply(s, v);
    #1 check_all();
  endtask : wr
  task automatic idle;
    @(posedge sys_clk);
    #1 wen = 1'b0;
    home = 1'b0;
    check_all();
  endtask : idle
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      conclude();
    end
  end
  initial
  begin
    mreset();
    @(posedge sys_clk);
    #1 check_all();
    @(posedge sys_clk);
    reset_n <= 1'b1;
    // too early: must be dropped
    lcd_host_model_inst.write(1'b0, 8'h3F, 1, 1'b0);
    #1 check_all();
    repeat (RC - 4) @(posedge sys_clk);
    #1 chk("ready", ready, 1'b0);
    @(posedge sys_clk);
    #1 chk("ready", ready, 1'b1);
    for (int bk = 0; bk < 2; bk++)
    begin
      wr(1'b0, {6'h0E, bk[0], 1'b1}, 1);
      for (int op = 1; op < 7; op++)
      begin
        b = {op[3:0], 4'($random(seed))};
        if (op == 3)
          b[1] = bk[0];
        wr(1'b0, b, 1);
      end
    end
    wr(1'b0, 8'h30, 1);
    for (int a = 0; a < 3; a++)
    begin
      wr(1'b0, {1'b1, a[1:0], 5'h00}, 1);
      for (int k = 0; k < 11; k++)
        wr(1'b1, 8'($random(seed)), 1);
    end
    wr(1'b0, 8'hA0, 1);
    wr(1'b1, 8'($random(seed)), 3);
    idle();
    wr(1'b0, 8'h3A, 1);
    wr(1'b0, 8'h85, 1);
    wr(1'b1, 8'h5A, 1);
    wr(1'b0, 8'h38, 1);
    wr(1'b0, 8'h10, 1);
    wr(1'b1, 8'hC3, 1);
    wr(1'b0, 8'h1F, 1);
    idle();
    // a test opcode on purpose, so the no-op has a mode to leave
    wr(1'b0, 8'h05, 1);
    wr(1'b0, 8'h00, 1);
    repeat (150)
    begin
      b = 8'($random(seed));
      if (b[0])
        wr(1'b1, b, 1);
      else if (b[7:4] == 4'h0 || b[7:4] == 4'h7)
        wr(1'b0, 8'h00, 1);
      else
        wr(1'b0, b, 1);
    end
    @(posedge sys_clk);
    reset_n <= 1'b0;
    mreset();
    @(posedge sys_clk);
    #1 check_all();
    // held the full 10 us that a host must give
    repeat (399) @(posedge sys_clk);
    reset_n <= 1'b1;
    wr(1'b0, 8'h3F, 1);
    conclude();
  end
endmodule : lcd_command_decoder_tb
